// file: rtl/aps_consts.svh
// Offsets, field positions, widths and fault codes of the preset unit.
// Assumes a 32-bit register port with byte addresses on word boundaries.
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH

`define APS_ADDR_W 8
`define APS_DATA_W 32
`define APS_OFF_CTRL 8'h00
`define APS_OFF_AXIS 8'h04
`define APS_OFF_POS 8'h08
`define APS_OFF_STAT 8'h0C
`define APS_OFF_INT_STAT 8'h10
`define APS_OFF_INT_MASK 8'h14
`define APS_OFF_VIEW_CMD 8'h18
`define APS_OFF_VIEW_ACT 8'h1C
`define APS_CTRL_EXEC_BIT 0
`define APS_CTRL_REL_BIT 1
`define APS_CTRL_REF_LSB 2
`define APS_CTRL_REF_W 2
`define APS_STAT_BUSY_BIT 0
`define APS_STAT_DONE_BIT 1
`define APS_STAT_ERR_BIT 2
`define APS_STAT_CODE_LSB 8
`define APS_INT_DONE_BIT 0
`define APS_INT_ERR_BIT 1
`define APS_INT_W 2
`define APS_CODE_W 8
`define APS_CODE_NONE 8'h00
`define APS_CODE_BAD_AXIS 8'h01
`define APS_CODE_BAD_REF 8'h02
`define APS_CODE_STOP_BUSY 8'h03
`define APS_REF_CMD 2'h0
`define APS_REF_ACT 2'h1
`define APS_NUM_AXES 4
`define APS_POS_W 32

`endif

// file: rtl/aps_pkg.sv
// Types used by the position preset unit alone; its bench uses none of them.
// Assumes aps_consts.svh is on the include path.
`include "aps_consts.svh"

package aps_pkg;

  typedef enum logic [1:0]
  {
    APS_IDLE,
    APS_BUSY,
    APS_DONE_HOLD,
    APS_ERR_HOLD
  } aps_state_t;

  // Command captured on the execute rising edge
  typedef struct packed
  {
    logic [7:0] axis;
    logic [`APS_DATA_W-1:0] position;
    logic relative;
    logic [`APS_CTRL_REF_W-1:0] ref_sel;
  } aps_req_t;

  // Handshake outputs
  typedef struct packed
  {
    logic busy;
    logic done;
    logic error;
    logic [`APS_CODE_W-1:0] fault_code;
  } aps_hs_t;

endpackage

// file: rtl/aps_preset.sv
// Axis position preset unit: overwrites stored commanded/measured positions.
// Assumes one 125 MHz clock, a plain register port, and stop-busy pins from
// the motion side that are asynchronous to this clock.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "aps_consts.svh"

// What this block does
// - Busy rises one period after execute is seen rising.
// - Done rises one period after busy, busy drops then.
// - Done holds while execute stays high, clears when it falls.
// - Execute dropped early: done still pulses for one period.
// - A fault raises error and drops busy in the same period.
// - Error for execution faults or illegal inputs, with a fault code.
// - Error holds until execute falls, then clears.
// - Only stored positions change; no motion is made or altered.
// - Relative mode: new position is sampled reference plus value.
// - Absolute mode: new position is the supplied value.
// - Reference position is sampled when the command begins.
// - Reference select 0 is commanded, 1 is measured position.
// - Commanded reference: load commanded, shift measured by same amount.
// - Measured reference: load measured, shift commanded by same amount.
// - Error when the axis does not support the reference type.
// - Presetting a master does not move its slaves.
// - Presetting a slave keeps its coupling to the master.
// - Rejected with error while an axis stop is executing.
module aps_preset #(
  parameter int NUM_AXES = `APS_NUM_AXES,
  parameter int POS_W = `APS_POS_W,
  // Bit 2a: commanded supported, bit 2a+1: measured supported, per axis
  parameter logic [2*NUM_AXES-1:0] REF_SUPPORT = {2*NUM_AXES{1'b1}}
)(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [`APS_ADDR_W-1:0] I_ADDR,
  input wire logic [`APS_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [NUM_AXES-1:0] I_STOP_BUSY,
  output logic [`APS_DATA_W-1:0] O_RDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ERROR,
  output logic [`APS_CODE_W-1:0] O_FAULT_CODE,
  output logic O_IRQ
);

  // ==========================================================================
  // Elaboration checks
  // The axis field is eight bits wide and positions fit one data word
  generate
    if (NUM_AXES < 2 || NUM_AXES > 256)
    begin : g_bad_num_axes
      $error("NUM_AXES must lie in 2..256");
    end
    if (POS_W < 2 || POS_W > `APS_DATA_W)
    begin : g_bad_pos_w
      $error("POS_W must lie in 2..32");
    end
    if ($bits(REF_SUPPORT) != 2 * NUM_AXES)
    begin : g_bad_ref_support
      $error("REF_SUPPORT needs two bits per axis");
    end
  endgenerate

  localparam int AXW = $clog2(NUM_AXES);

  // ==========================================================================
  // Declarations
  logic [`APS_DATA_W-1:0] ctrl;
  logic [7:0] axis_sel;
  logic [`APS_DATA_W-1:0] pos_val;
  logic [`APS_INT_W-1:0] int_stat;
  logic [`APS_INT_W-1:0] int_mask;
  logic exec_q;
  logic exec_rise;
  logic exec_fall;
  logic [NUM_AXES-1:0] stop_meta;
  logic [NUM_AXES-1:0] stop_sync;
  aps_pkg::aps_state_t state;
  aps_pkg::aps_req_t req;
  aps_pkg::aps_hs_t hs;
  // Stored positions, one commanded and one measured value per axis
  logic signed [POS_W-1:0] cmd_pos [NUM_AXES];
  logic signed [POS_W-1:0] act_pos [NUM_AXES];
  logic signed [POS_W-1:0] ref_pos;
  logic signed [POS_W-1:0] target;
  logic signed [POS_W-1:0] shift_amt;
  logic [AXW-1:0] req_ax;
  logic [AXW-1:0] view_ax;
  logic axis_ok;
  logic ref_ok;
  logic commit;
  logic ev_done;
  logic ev_err;
  logic [`APS_CODE_W-1:0] next_code;

  // ==========================================================================
  // Register writes
  // Status and position views are read-only; writes to them are dropped
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ctrl <= '0;
      axis_sel <= 8'h00;
      pos_val <= '0;
      int_mask <= '0;
    end
    else if (I_WR)
    begin
      if (I_ADDR == `APS_OFF_CTRL)
        ctrl <= I_WDATA;
      else if (I_ADDR == `APS_OFF_AXIS)
        axis_sel <= I_WDATA[7:0];
      else if (I_ADDR == `APS_OFF_POS)
        pos_val <= I_WDATA;
      else if (I_ADDR == `APS_OFF_INT_MASK)
        int_mask <= I_WDATA[`APS_INT_W-1:0];
    end
  end

  // ==========================================================================
  // Interrupt status and request
  // Sticky events; a new event in the clearing cycle survives
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      int_stat <= '0;
    else
    begin
      if (I_WR && I_ADDR == `APS_OFF_INT_STAT)
        int_stat <= (int_stat & ~I_WDATA[`APS_INT_W-1:0])
                    | {ev_err, ev_done};
      else
        int_stat <= int_stat | {ev_err, ev_done};
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(int_stat & int_mask);
  end

  // ==========================================================================
  // Stop-busy pins come from the motion clock, hence two flops
  // Only the second stage is read, so a metastable first stage never spreads
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      stop_meta <= '0;
      stop_sync <= '0;
    end
    else
    begin
      stop_meta <= I_STOP_BUSY;
      stop_sync <= stop_meta;
    end
  end

  // ==========================================================================
  // Execute edge detection
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      exec_q <= 1'b0;
    else
      exec_q <= ctrl[`APS_CTRL_EXEC_BIT];
  end

  assign exec_rise = ctrl[`APS_CTRL_EXEC_BIT] & ~exec_q;
  assign exec_fall = ~ctrl[`APS_CTRL_EXEC_BIT] & exec_q;

  // ==========================================================================
  // Capture of command and reference at the start of execution
  assign view_ax = axis_sel[AXW-1:0];
  assign req_ax = req.axis[AXW-1:0];

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      req <= '0;
      ref_pos <= '0;
    end
    else if (state == aps_pkg::APS_IDLE && exec_rise)
    begin
      // A rise during a done or error hold is refused, not queued
      // Inputs are trusted stable on this edge
      req.axis <= axis_sel;
      req.position <= pos_val;
      req.relative <= ctrl[`APS_CTRL_REL_BIT];
      req.ref_sel <= ctrl[`APS_CTRL_REF_LSB +: `APS_CTRL_REF_W];
      // Reference sampled now, not at commit
      if (ctrl[`APS_CTRL_REF_LSB +: `APS_CTRL_REF_W] == `APS_REF_ACT)
        ref_pos <= act_pos[view_ax];
      else
        ref_pos <= cmd_pos[view_ax];
    end
  end

  // ==========================================================================
  // Fault checks on the captured request
  always_comb
  begin
    axis_ok = int'(req.axis) < NUM_AXES;
    ref_ok = 1'b0;
    if (axis_ok && req.ref_sel == `APS_REF_CMD)
      ref_ok = REF_SUPPORT[2 * req_ax];
    else if (axis_ok && req.ref_sel == `APS_REF_ACT)
      ref_ok = REF_SUPPORT[2 * req_ax + 1];
    // First failed check names the code: axis, then reference, then stop
    if (!axis_ok)
      next_code = `APS_CODE_BAD_AXIS;
    else if (!ref_ok)
      next_code = `APS_CODE_BAD_REF;
    else if (stop_sync[req_ax])
      next_code = `APS_CODE_STOP_BUSY;
    else
      next_code = `APS_CODE_NONE;
  end

  // ==========================================================================
  // New position; the sum wraps at POS_W bits and no overflow is flagged
  always_comb
  begin
    if (req.relative)
      target = ref_pos + POS_W'(req.position);
    else
      target = POS_W'(req.position);
    shift_amt = target - ref_pos;
  end

  assign commit = state == aps_pkg::APS_BUSY && next_code == `APS_CODE_NONE;
  assign ev_done = commit;
  assign ev_err = state == aps_pkg::APS_BUSY && next_code != `APS_CODE_NONE;

  // ==========================================================================
  // Position store; only the addressed axis changes, no coupled axis is
  // touched and no motion request is raised
  generate
    for (genvar a = 0; a < NUM_AXES; a++)
    begin : g_axis
      always_ff @(posedge I_CLK)
      begin
        if (!I_RST_N)
        begin
          cmd_pos[a] <= '0;
          act_pos[a] <= '0;
        end
        else if (commit && req_ax == AXW'(a))
        begin
          // Deviation between the two kept constant
          if (req.ref_sel == `APS_REF_ACT)
          begin
            act_pos[a] <= target;
            cmd_pos[a] <= cmd_pos[a] + shift_amt;
          end
          else
          begin
            cmd_pos[a] <= target;
            act_pos[a] <= act_pos[a] + shift_amt;
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Handshake sequence
  // Busy lasts one period; every exit from it lands in a hold state
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state <= aps_pkg::APS_IDLE;
      hs <= '0;
    end
    else
    begin
      case (state)
        aps_pkg::APS_BUSY:
        begin
          hs.busy <= 1'b0;
          if (next_code != `APS_CODE_NONE)
          begin
            hs.error <= 1'b1;
            hs.fault_code <= next_code;
            state <= aps_pkg::APS_ERR_HOLD;
          end
          else
          begin
            hs.done <= 1'b1;
            state <= aps_pkg::APS_DONE_HOLD;
          end
        end
        aps_pkg::APS_DONE_HOLD:
        begin
          // Held while execute is high, else a single period
          if (!ctrl[`APS_CTRL_EXEC_BIT])
          begin
            hs.done <= 1'b0;
            state <= aps_pkg::APS_IDLE;
          end
        end
        aps_pkg::APS_ERR_HOLD:
        begin
          // Execute already low clears after one period
          if (!ctrl[`APS_CTRL_EXEC_BIT] || exec_fall)
          begin
            hs.error <= 1'b0;
            hs.fault_code <= `APS_CODE_NONE;
            state <= aps_pkg::APS_IDLE;
          end
        end
        default:
        begin
          if (exec_rise)
          begin
            hs.busy <= 1'b1;
            state <= aps_pkg::APS_BUSY;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Outputs, each a handshake flop passed straight through
  always_comb
  begin
    O_BUSY = hs.busy;
    O_DONE = hs.done;
    O_ERROR = hs.error;
    O_FAULT_CODE = hs.fault_code;
  end

  // ==========================================================================
  // Read port; data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_RDATA <= '0;
    else if (I_RD)
    begin
      if (I_ADDR == `APS_OFF_CTRL)
        O_RDATA <= ctrl;
      else if (I_ADDR == `APS_OFF_AXIS)
        O_RDATA <= {24'h000000, axis_sel};
      else if (I_ADDR == `APS_OFF_POS)
        O_RDATA <= pos_val;
      else if (I_ADDR == `APS_OFF_STAT)
        O_RDATA <= {16'h0000, hs.fault_code, 5'h00, hs.error, hs.done, hs.busy};
      else if (I_ADDR == `APS_OFF_INT_STAT)
        O_RDATA <= {30'h00000000, int_stat};
      else if (I_ADDR == `APS_OFF_INT_MASK)
        O_RDATA <= {30'h00000000, int_mask};
      else if (I_ADDR == `APS_OFF_VIEW_CMD)
        O_RDATA <= `APS_DATA_W'(cmd_pos[view_ax]);
      else if (I_ADDR == `APS_OFF_VIEW_ACT)
        O_RDATA <= `APS_DATA_W'(act_pos[view_ax]);
      else
        O_RDATA <= '0;
    end
    else
      O_RDATA <= '0;
  end

endmodule

// file: testbench/aps_preset_sva.sv
// Checker for the handshake and read port of the position preset unit.
// Assumes it is bound to aps_preset and sees only its ports.
`timescale 1ns/1ps
`include "aps_consts.svh"
module aps_preset_chk (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [`APS_ADDR_W-1:0] I_ADDR,
  input wire logic [`APS_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [`APS_DATA_W-1:0] O_RDATA,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_ERROR,
  input wire logic [`APS_CODE_W-1:0] O_FAULT_CODE
);
  // =====
  // Shadow of the execute bit
  logic exec;
  logic go;
  assign go = I_WR && I_ADDR == `APS_OFF_CTRL && I_WDATA[0] && !exec
    && !(O_BUSY || O_DONE || O_ERROR);
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      exec <= 1'b0;
    else if (I_WR && I_ADDR == `APS_OFF_CTRL)
      exec <= I_WDATA[0];
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // =====
  // Assertions
  a_busy_start: assert property (go |=> ##1 O_BUSY)
    else $error("busy did not rise");
  a_busy_short: assert property (O_BUSY |=> !O_BUSY && (O_DONE || O_ERROR))
    else $error("busy not ended by done or error");
  a_busy_alone: assert property (O_BUSY |-> !O_DONE && !O_ERROR)
    else $error("busy beside done or error");
  a_done_hold: assert property (O_DONE && exec |=> O_DONE)
    else $error("done dropped early");
  a_done_clear: assert property (O_DONE && !exec |-> ##[1:2] !O_DONE)
    else $error("done stuck");
  a_err_hold: assert property (O_ERROR && exec |=> O_ERROR)
    else $error("error dropped early");
  a_err_clear: assert property (O_ERROR && !exec |-> ##[1:2] !O_ERROR)
    else $error("error stuck");
  a_code_match: assert property ((O_FAULT_CODE != `APS_CODE_NONE) == O_ERROR)
    else $error("fault code disagrees with error");
  a_read_idle: assert property (!$past(I_RD) |-> O_RDATA == '0)
    else $error("read data outside read slot");
  cover property ($rose(O_DONE));
  cover property ($rose(O_ERROR));
  cover property (O_DONE && !exec);
endmodule
bind aps_preset aps_preset_chk u_chk (.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .O_BUSY, .O_DONE, .O_ERROR, .O_FAULT_CODE);

// file: testbench/aps_stop_model.sv
// Motion-side model: one axis reports a stop in progress for a set time.
// Assumes a one-cycle start pulse; the level is plain, the unit syncs it.
`timescale 1ns/1ps
module aps_stop_model #(
  parameter int NUM_AXES = 4
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [7:0] i_axis,
  input wire logic [7:0] i_len,
  output logic [NUM_AXES-1:0] o_stop_busy
);
  logic [7:0] left;
  logic [NUM_AXES-1:0] mask;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      left <= 8'h00;
    else if (i_start)
      left <= i_len;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_start)
      mask <= NUM_AXES'(1) << i_axis;
  end
  // Low once the stop ends, so a later preset is accepted
  assign o_stop_busy = (left != 8'h00) ? mask : '0;
endmodule

// file: testbench/test_axis_position_preset.sv
// Self-checking bench for the position preset unit.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`include "aps_consts.svh"
module test_axis_position_preset;
  logic I_CLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [3:0] I_STOP_BUSY;
  logic [31:0] O_RDATA;
  logic O_BUSY, O_DONE, O_ERROR, O_IRQ;
  logic [7:0] O_FAULT_CODE;
  logic st_go = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  initial forever #4 I_CLK = ~I_CLK;
  aps_stop_model #(.NUM_AXES(4)) u_stop (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_start(st_go),
    .i_axis(8'h02), .i_len(8'h20), .o_stop_busy(I_STOP_BUSY));
  aps_preset DUT (.I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .I_STOP_BUSY,
    .O_RDATA, .O_BUSY, .O_DONE, .O_ERROR, .O_FAULT_CODE, .O_IRQ);
  // =====
  // Tasks
  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge I_CLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 check(O_RDATA, exp);
  endtask
  // Whole command: busy, outcome, hold while execute stays high, clear on drop
  task automatic run(input logic [7:0] ax, input logic [31:0] p, input logic [3:0] c,
    input logic [7:0] code);
    logic [10:0] hs;
    hs = {1'b0, code == 8'h00, code != 8'h00, code};
    wr(8'h04, {24'h0, ax});
    wr(8'h08, p);
    wr(8'h00, {28'h0, c});
    @(posedge I_CLK);
    #1 check(O_BUSY, 1'b1);
    @(posedge I_CLK);
    #1 check(32'({O_BUSY, O_DONE, O_ERROR, O_FAULT_CODE}), hs);
    repeat (3) @(posedge I_CLK);
    #1 check(32'({O_BUSY, O_DONE, O_ERROR, O_FAULT_CODE}), hs);
    wr(8'h00, 32'h0);
    repeat (2) @(posedge I_CLK);
    #1 check(32'({O_BUSY, O_DONE, O_ERROR, O_FAULT_CODE}), 0);
  endtask
  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      final_report();
    end
  end
  // =====
  // Sequence
  initial
  begin
    repeat (4) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    wr(8'h14, 32'h1);
    rd(8'h40, 32'h0);
    run(8'h01, 32'h1000, 4'h1, `APS_CODE_NONE);
    rd(8'h18, 32'h1000);
    rd(8'h1C, 32'h1000);
    check(O_IRQ, 1'b1);
    rd(8'h10, 32'h1);
    wr(8'h10, 32'h1);
    repeat (2) @(posedge I_CLK);
    #1 check(O_IRQ, 1'b0);
    run(8'h01, 32'h20, 4'h7, `APS_CODE_NONE);
    rd(8'h1C, 32'h1020);
    rd(8'h18, 32'h1020);
    run(8'h01, 32'hFFFFFFF0, 4'h3, `APS_CODE_NONE);
    rd(8'h18, 32'h1010);
    wr(8'h10, 32'h1);
    run(8'h01, 32'h0, 4'h9, `APS_CODE_BAD_REF);
    run(8'h01, 32'h0, 4'hD, `APS_CODE_BAD_REF);
    rd(8'h18, 32'h1010);
    rd(8'h10, 32'h2);
    check(O_IRQ, 1'b0);
    run(8'h04, 32'h0, 4'h1, `APS_CODE_BAD_AXIS);
    wr(8'h04, 32'h0);
    rd(8'h18, 32'h0);
    @(posedge I_CLK);
    st_go <= 1'b1;
    @(posedge I_CLK);
    st_go <= 1'b0;
    run(8'h02, 32'h5, 4'h1, `APS_CODE_STOP_BUSY);
    repeat (40) @(posedge I_CLK);
    run(8'h02, 32'h5, 4'h1, `APS_CODE_NONE);
    rd(8'h18, 32'h5);
    // Execute dropped the cycle after it rose
    @(posedge I_CLK);
    I_ADDR <= 8'h00;
    I_WDATA <= 32'h1;
    I_WR <= 1'b1;
    @(posedge I_CLK);
    I_WDATA <= 32'h0;
    @(posedge I_CLK);
    I_WR <= 1'b0;
    #1 check(O_BUSY, 1'b1);
    @(posedge I_CLK);
    #1 check(O_DONE, 1'b1);
    @(posedge I_CLK);
    #1 check(O_DONE, 1'b0);
    final_report();
  end
endmodule
